/* verilog/sca_pkg.sv */
package sca_pkg;
  // Result and command widths
  localparam int SCA_RES_W = 13;
  localparam int SCA_BUS_W = 8;
  localparam int SCA_CMD_W = 6;
  localparam int SCA_CNT_W = 7;
  localparam int SCA_CAP_W = 3;
  // Last index of the internal capacitors calibrated one per conversion
  localparam logic [SCA_CAP_W-1:0] SCA_CAP_LAST = 3'h6;
  localparam logic [SCA_CAP_W-1:0] SCA_CAP_FIRST = 3'h0;
  // Sequence cycle figures, in conversion clock cycles
  localparam logic [SCA_CNT_W-1:0] SCA_CYC_FIRST = 7'h01;
  localparam logic [SCA_CNT_W-1:0] SCA_M1_CONV_LAST = 7'h3E;
  localparam logic [SCA_CNT_W-1:0] SCA_M2_CONV_LAST = 7'h18;
  localparam logic [SCA_CNT_W-1:0] SCA_CAL_LAST = 7'h69;
  localparam logic [SCA_CNT_W-1:0] SCA_M1_SAMP_FIRST = 7'h29;
  localparam logic [SCA_CNT_W-1:0] SCA_M1_SAMP_LAST = 7'h31;
  localparam logic [SCA_CNT_W-1:0] SCA_M2_SAMP_FIRST = 7'h03;
  localparam logic [SCA_CNT_W-1:0] SCA_M2_SAMP_LAST = 7'h0A;
  // Status byte bit positions
  localparam int SCA_ST_ACTIVE = 6;
  localparam int SCA_ST_PTR = 2;
  localparam int SCA_ST_EOC = 1;
  localparam int SCA_ST_DONE = 0;
  // Command word bit positions (command_bit5 .. command_bit0)
  localparam int SCA_CMD_B5 = 5;
  localparam int SCA_CMD_B4 = 4;
  localparam int SCA_CMD_B0 = 0;
  localparam int SCA_CMD_B3 = 3;
  // Conversion clock divider default: 50 MHz / 20 = 2.5 MHz
  localparam int SCA_CLK_DIV_DEF = 20;
  // Core cycles the ready output holds its wait state
  localparam logic [1:0] SCA_READY_WAIT = 2'h1;
  // Sequence kinds
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV1, SEQ_CONV2, SEQ_CAL} sca_seq_t;
endpackage : sca_pkg

/* verilog/sca_seq_if.sv */
interface sca_seq_if;
  import sca_pkg::*;
  // One-cycle conversion clock enable
  logic tick;
  // Restart and abort requests
  logic start;
  logic abort;
  // Final cycle of the sequence being started
  logic [SCA_CNT_W-1:0] lastCycle;
  // Counter state
  logic [SCA_CNT_W-1:0] count;
  logic running;
  logic done;
  modport ctrl (output tick, output start, output abort, output lastCycle,
    input count, input running, input done);
  modport cnt (input tick, input start, input abort, input lastCycle,
    output count, output running, output done);
endinterface : sca_seq_if

/* verilog/sca_pin_sync.sv */
module sca_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // Two-flop synchroniser, idle high to match inactive strobes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '1;
      pinSync <= '1;
    end else begin
      meta_r <= pinIn;
      pinSync <= meta_r;
    end
  end
endmodule : sca_pin_sync

/* verilog/sca_seq_counter.sv */
module sca_seq_counter import sca_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  sca_seq_if.cnt seq
);
  // Final cycle captured at start
  logic [SCA_CNT_W-1:0] last_r;

  // Cycle counter: restart on start, stop at final cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq.count <= '0;
      seq.running <= 1'b0;
      seq.done <= 1'b0;
      last_r <= '0;
    end else begin
      seq.done <= 1'b0;
      if (seq.abort) begin
        seq.running <= 1'b0;
        seq.count <= '0;
      end else if (seq.start) begin
        seq.running <= 1'b1;
        seq.count <= SCA_CYC_FIRST;
        last_r <= seq.lastCycle;
      end else if (seq.running && seq.tick) begin
        if (seq.count == last_r) begin
          seq.running <= 1'b0;
          seq.done <= 1'b1;
        end else begin
          seq.count <= seq.count + SCA_CYC_FIRST;
        end
      end
    end
  end
endmodule : sca_seq_counter

/* verilog/sca_adc_ctrl.sv */
// Overview of operation
// - Mode 1 samples input in cycles 41-49.
// - Mode 2 samples input in cycles 3-10.
// - Completion drives interrupt low; restart allowed.
// - Mode 1 ends cycle 62, Mode 2 cycle 24.
// - New start aborts and restarts running conversion.
// - Abort before sampling recalibrates same capacitor.
// - Data pins driven only during read strobes.
// - Status byte layout on status read.
// - Active flag high while conversion runs.
// - Byte pointer toggles per result read, status-write clears.
// - EOC and done set on completion; reads clear done.
// - Result reads alternate MSB then LSB.
// - Sign-extended two's complement, right justified.
// - No-status variant drives all 13 bits.
// - Read or write combination releases interrupt.
// - Ready output inserts host wait state.
// - Status write resets flags, aborts conversion.
// - Mode select low Mode 1, high Mode 2.
// - Mode 1 rotates through seven capacitors.
// - Mode 1 starts on chip select plus write.
// - Mode 2 calibrate 105, convert 24 cycles.
// - Mode 2 command latched on strobe rise.
// - Mode 2 command bit encoding.
// - Stopped clock loses calibration.
// - Mode 1 power-up calibration, 105 cycles.
module sca_adc_ctrl import sca_pkg::*; #(
  parameter int CLK_DIV = SCA_CLK_DIV_DEF,
  parameter bit HAS_STATUS = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic statusN,
  input wire logic modeSel,
  input wire logic clkHalt,
  input wire logic [SCA_CMD_W-1:0] dataIn,
  input wire logic [SCA_RES_W-1:0] convResult,
  output logic [SCA_RES_W-1:0] dataOut,
  output logic [SCA_RES_W-1:0] dataOe,
  output logic intN,
  output logic readyOut,
  output logic sampleEn,
  output logic calOneCap,
  output logic calAllCaps,
  output logic [SCA_CAP_W-1:0] calCapIdx,
  output logic calValid
);
  localparam int DIV_W = $clog2(CLK_DIV);

  // Divider must give a real slower rate
  if (CLK_DIV < 2) begin : gDivCheck
    $error("CLK_DIV must be at least 2");
  end

  // Synchronised pins
  logic csS, rdS, wrS, statS, modeS, haltS;
  logic [SCA_CMD_W-1:0] dataS;
  // Combined strobes and their previous values
  logic rdAct, wrAct, rdPrev_r, wrPrev_r;
  logic rdRise, wrRise, wrFall;
  // Decoded requests
  logic statusWr, startConv1, startConv2, startCal2, autoCal, seqStart;
  logic cmdIsConv, cmdIsCal, statHigh, resultRead, statusRead;
  // Divider state
  logic [DIV_W-1:0] divCnt_r;
  logic tick_r;
  // Sequence state
  sca_seq_t seqKind_r, startKind;
  logic [SCA_CNT_W-1:0] startLast;
  logic convDone, calDone, inSample;
  // Command, capacitor and flag registers
  logic [SCA_CMD_W-1:0] cmd_r;
  logic [SCA_CAP_W-1:0] capIdx_r;
  logic capUsed_r;
  logic calValid_r;
  logic [SCA_RES_W-1:0] result_r;
  logic bytePtr_r, eoc_r, done_r;
  logic [1:0] readyCnt_r;
  logic [SCA_BUS_W-1:0] statusByte;

  sca_seq_if seq ();

  // Strobes and status pin pass two flops
  sca_pin_sync #(.WIDTH(6)) uCtlSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn({csN, rdN, wrN, statusN, modeSel, clkHalt}),
    .pinSync({csS, rdS, wrS, statS, modeS, haltS})
  );

  // Command bits pass two flops
  sca_pin_sync #(.WIDTH(SCA_CMD_W)) uDataSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn(dataIn),
    .pinSync(dataS)
  );

  sca_seq_counter uCnt (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .seq(seq.cnt)
  );

  // Conversion clock enable from core clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_r <= '0;
      tick_r <= 1'b0;
    end else if (divCnt_r == DIV_W'(CLK_DIV - 1)) begin
      divCnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + DIV_W'(1);
      tick_r <= 1'b0;
    end
  end

  // Strobe edge history
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPrev_r <= 1'b0;
      wrPrev_r <= 1'b0;
    end else begin
      rdPrev_r <= rdAct;
      wrPrev_r <= wrAct;
    end
  end

  // Strobe decode
  always_comb begin
    rdAct = !csS && !rdS;
    wrAct = !csS && !wrS;
    rdRise = rdAct && !rdPrev_r;
    wrRise = wrAct && !wrPrev_r;
    wrFall = !wrAct && wrPrev_r;
    // Without status logic the status pin is absent
    statHigh = !HAS_STATUS || statS;
    cmdIsConv = cmd_r[SCA_CMD_B5] && !cmd_r[SCA_CMD_B4] && !cmd_r[SCA_CMD_B0];
    cmdIsCal = !cmd_r[SCA_CMD_B5] && (cmd_r[SCA_CMD_B3:SCA_CMD_B0] == '0);
  end

  // Request decode
  always_comb begin
    statusWr = HAS_STATUS && wrRise && !statS;
    startConv1 = !modeS && wrRise && statHigh && calValid_r && seqKind_r != SEQ_CAL;
    // Mode 2 start on strobe release
    startConv2 = modeS && wrFall && statHigh && cmdIsConv;
    startCal2 = modeS && wrFall && statHigh && cmdIsCal;
    // automatic calibration once the clock runs again
    autoCal = !modeS && !calValid_r && !haltS && seqKind_r == SEQ_IDLE && !seq.running;
    seqStart = !statusWr && (startConv1 || startConv2 || startCal2 || autoCal);
    resultRead = rdRise && statHigh;
    statusRead = rdRise && HAS_STATUS && !statS;
  end

  // Kind and length of the sequence being started
  always_comb begin
    startKind = SEQ_IDLE;
    startLast = SCA_CAL_LAST;
    if (startConv1) begin
      startKind = SEQ_CONV1;
      startLast = SCA_M1_CONV_LAST;
    end else if (startConv2) begin
      startKind = SEQ_CONV2;
      startLast = SCA_M2_CONV_LAST;
    end else if (startCal2 || autoCal) begin
      startKind = SEQ_CAL;
      startLast = SCA_CAL_LAST;
    end
  end

  // Counter controls
  always_comb begin
    seq.tick = tick_r;
    seq.start = seqStart;
    seq.abort = statusWr;
    seq.lastCycle = startLast;
  end

  // Sequence end and sampling window
  always_comb begin
    convDone = seq.done && (seqKind_r == SEQ_CONV1 || seqKind_r == SEQ_CONV2);
    calDone = seq.done && seqKind_r == SEQ_CAL;
    inSample = 1'b0;
    if (seq.running && seqKind_r == SEQ_CONV1) begin
      inSample = seq.count >= SCA_M1_SAMP_FIRST && seq.count <= SCA_M1_SAMP_LAST;
    end else if (seq.running && seqKind_r == SEQ_CONV2) begin
      inSample = seq.count >= SCA_M2_SAMP_FIRST && seq.count <= SCA_M2_SAMP_LAST;
    end
  end

  // Kind of running sequence
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seqKind_r <= SEQ_IDLE;
    end else if (statusWr) begin
      seqKind_r <= SEQ_IDLE;
    end else if (seqStart) begin
      seqKind_r <= startKind;
    end else if (seq.done) begin
      seqKind_r <= SEQ_IDLE;
    end
  end

  // Command word latch while write combination is low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r <= '0;
    end else if (wrAct) begin
      cmd_r <= dataS;
    end
  end

  // Capacitor rotation for Mode 1
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capIdx_r <= SCA_CAP_FIRST;
      capUsed_r <= 1'b0;
    end else if (statusWr) begin
      capIdx_r <= SCA_CAP_FIRST;
      capUsed_r <= 1'b0;
    end else if (startConv1 && seqStart) begin
      // advance only if last one reached sampling
      if (capUsed_r) begin
        capIdx_r <= (capIdx_r == SCA_CAP_LAST) ? SCA_CAP_FIRST : capIdx_r + 3'h1;
      end
      capUsed_r <= 1'b0;
    end else if (seq.running && seqKind_r == SEQ_CONV1 && seq.count >= SCA_M1_SAMP_FIRST) begin
      capUsed_r <= 1'b1;
    end
  end

  // Calibration validity
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      calValid_r <= 1'b0;
    end else if (haltS) begin
      calValid_r <= 1'b0;
    end else if (calDone) begin
      calValid_r <= 1'b1;
    end
  end

  // Result latch at completion
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= '0;
    end else if (convDone) begin
      result_r <= convResult;
    end
  end

  // End-of-conversion and done flags, set wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eoc_r <= 1'b0;
      done_r <= 1'b0;
    end else if (convDone) begin
      eoc_r <= 1'b1;
      done_r <= 1'b1;
    end else begin
      if (statusWr || (seqStart && startKind != SEQ_CAL)) begin
        eoc_r <= 1'b0;
      end
      // reads and status write clear done
      if (statusWr || resultRead || statusRead) begin
        done_r <= 1'b0;
      end
    end
  end

  // Byte pointer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bytePtr_r <= 1'b0;
    end else if (statusWr) begin
      bytePtr_r <= 1'b0;
    end else if (resultRead && HAS_STATUS) begin
      bytePtr_r <= !bytePtr_r;
    end
  end

  // Interrupt output, completion wins over release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      intN <= 1'b1;
    end else if (convDone) begin
      intN <= 1'b0;
    end else if (rdRise || wrRise) begin
      intN <= 1'b1;
    end
  end

  // Status byte assembly
  always_comb begin
    statusByte = '0;
    statusByte[SCA_ST_ACTIVE] = seq.running && seqKind_r != SEQ_CAL;
    statusByte[SCA_ST_PTR] = bytePtr_r;
    statusByte[SCA_ST_EOC] = eoc_r;
    statusByte[SCA_ST_DONE] = done_r;
  end

  // Read data and pin drive
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut <= '0;
      dataOe <= '0;
    end else if (rdRise) begin
      dataOe <= '0;
      if (!HAS_STATUS) begin
        dataOut <= result_r;
        dataOe <= '1;
      end else if (!statS) begin
        dataOut <= {5'h00, statusByte};
        dataOe[SCA_BUS_W-1:0] <= '1;
      end else if (!bytePtr_r) begin
        dataOut <= {5'h00, {4{result_r[12]}}, result_r[11:8]};
        dataOe[SCA_BUS_W-1:0] <= '1;
      end else begin
        dataOut <= {5'h00, result_r[7:0]};
        dataOe[SCA_BUS_W-1:0] <= '1;
      end
    end else if (!rdAct) begin
      dataOe <= '0;
    end
  end

  // Ready output wait state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      readyOut <= 1'b1;
      readyCnt_r <= '0;
    end else if (rdRise) begin
      readyOut <= 1'b0;
      readyCnt_r <= SCA_READY_WAIT;
    end else if (readyCnt_r > 2'h1) begin
      readyCnt_r <= readyCnt_r - 2'h1;
    end else begin
      readyOut <= 1'b1;
      readyCnt_r <= '0;
    end
  end

  // Analog control outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampleEn <= 1'b0;
      calOneCap <= 1'b0;
      calAllCaps <= 1'b0;
      calCapIdx <= SCA_CAP_FIRST;
      calValid <= 1'b0;
    end else begin
      sampleEn <= inSample;
      calOneCap <= seq.running && seqKind_r == SEQ_CONV1 && seq.count < SCA_M1_SAMP_FIRST;
      calAllCaps <= seq.running && seqKind_r == SEQ_CAL;
      calCapIdx <= capIdx_r;
      calValid <= calValid_r;
    end
  end
endmodule : sca_adc_ctrl

/* bench/sca_adc_ctrl_chk.sv */
module sca_adc_ctrl_chk import sca_pkg::*; #(
  parameter int CLK_DIV = SCA_CLK_DIV_DEF,
  parameter bit HAS_STATUS = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic statusN,
  input wire logic [SCA_RES_W-1:0] dataOe,
  input wire logic intN,
  input wire logic readyOut,
  input wire logic modeSel,
  input wire logic sampleEn,
  input wire logic calOneCap,
  input wire logic calAllCaps,
  input wire logic [SCA_CAP_W-1:0] calCapIdx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode 2 tail from window close to completion, in core cycles
  localparam int TAIL_LO = 14 * CLK_DIV - 3;
  localparam int TAIL_HI = 14 * CLK_DIV + 3;
  // Sampling window lengths in core cycles
  localparam int WIN1 = 9 * CLK_DIV;
  localparam int WIN2 = 8 * CLK_DIV;
  // Cycles the sampling window has been open
  logic [15:0] sampRun_r;
  // Counts open-window cycles, clears when closed
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampRun_r <= 16'h0000;
    end else begin
      sampRun_r <= sampleEn ? sampRun_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_BUS_IDLE: assert property (rdN [*5] |-> dataOe == '0)
    else $error("Data pins driven without a read");
  AST_READY_PULSE: assert property ($fell(readyOut) |=> readyOut)
    else $error("Wait state longer than one cycle");
  AST_READY_READ: assert property ($fell(readyOut) |-> dataOe != '0 && !rdN && !csN)
    else $error("Wait state outside a read");
  AST_INT_RD: assert property ($fell(rdN) && !csN |-> ##[1:5] intN)
    else $error("Completion not released by read");
  AST_INT_WR: assert property ($fell(wrN) && !csN |-> ##[1:5] intN)
    else $error("Completion not released by write");
  AST_WIN_M1: assert property ($fell(sampleEn) && !modeSel |-> sampRun_r == 16'(WIN1))
    else $error("Mode 1 sampling window length wrong");
  AST_WIN_M2: assert property ($fell(sampleEn) && modeSel |-> sampRun_r == 16'(WIN2))
    else $error("Mode 2 sampling window length wrong");
  AST_M2_END: assert property ($fell(sampleEn) && modeSel |-> intN ##[TAIL_LO:TAIL_HI] !intN)
    else $error("Mode 2 conversion end misplaced");
  AST_SW_ABORT: assert property (HAS_STATUS && $fell(wrN) && !csN && !statusN
    |-> ##6 (!calOneCap && !sampleEn))
    else $error("Status write did not abort");
  AST_CAP_RANGE: assert property (calCapIdx <= SCA_CAP_LAST)
    else $error("Capacitor index out of range");
  AST_CAL_EXCL: assert property (calOneCap |-> !sampleEn && !calAllCaps)
    else $error("Calibration overlaps sampling");
endmodule : sca_adc_ctrl_chk

bind sca_adc_ctrl sca_adc_ctrl_chk #(.CLK_DIV(CLK_DIV), .HAS_STATUS(HAS_STATUS)) chk (
  .core_clk(core_clk), .arst_n(arst_n), .csN(csN), .rdN(rdN), .wrN(wrN), .statusN(statusN),
  .dataOe(dataOe), .intN(intN), .readyOut(readyOut), .modeSel(modeSel), .sampleEn(sampleEn),
  .calOneCap(calOneCap), .calAllCaps(calAllCaps), .calCapIdx(calCapIdx));

/* bench/sca_host_model.sv */
module sca_host_model import sca_pkg::*; (
  input wire logic core_clk,
  input wire logic [SCA_RES_W-1:0] dataOut,
  input wire logic [SCA_RES_W-1:0] dataOe,
  input wire logic [SCA_RES_W-1:0] altOut,
  input wire logic readyOut,
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic statusN,
  output logic [SCA_CMD_W-1:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    statusN = 1'b1;
    dataIn = 6'h15;
  end
  // command held over the strobe rise
  task automatic doWrite(input logic stLow, input logic [SCA_CMD_W-1:0] cmd);
    @(negedge core_clk);
    statusN = ~stLow;
    dataIn = cmd;
    csN = 1'b0;
    wrN = 1'b0;
    repeat (4) @(negedge core_clk);
    wrN = 1'b1;
    csN = 1'b1;
    repeat (4) @(negedge core_clk);
    // Hold time over: lines no longer show the word
    dataIn = ~cmd;
    statusN = 1'b1;
  endtask : doWrite
  // read held until the wait state has passed
  task automatic doRead(input logic stLow, output logic [SCA_RES_W-1:0] v,
    output logic [SCA_RES_W-1:0] oe, output logic [SCA_RES_W-1:0] va);
    @(negedge core_clk);
    statusN = ~stLow;
    csN = 1'b0;
    rdN = 1'b0;
    for (int i = 0; i < 12 && readyOut !== 1'b0; i++) @(negedge core_clk);
    // Ready sampled low at the next edge, high at the one after
    repeat (2) @(posedge core_clk);
    v = dataOut;
    oe = dataOe;
    va = altOut;
    @(negedge core_clk);
    rdN = 1'b1;
    csN = 1'b1;
    repeat (4) @(negedge core_clk);
    statusN = 1'b1;
  endtask : doRead
endmodule : sca_host_model

/* bench/sca_adc_ctrl_tb_top.sv */
module sca_adc_ctrl_tb_top import sca_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // Short conversion clock divide keeps the run brief
  localparam int DIV = 2;
  // Design pins
  logic core_clk, arst_n, csN, rdN, wrN, statusN, modeSel, clkHalt;
  logic intN, readyOut, sampleEn, calOneCap, calAllCaps, calValid;
  logic [SCA_CMD_W-1:0] dataIn;
  logic [SCA_RES_W-1:0] convResult, dataOut, dataOe, altOut;
  logic [SCA_CAP_W-1:0] calCapIdx;
  // Scoreboard counters and cycle count
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  // Reference model: pointer, flags and latched result
  int mPtr, mEoc, mDone, mRes;
  logic [31:0] rngState = 32'h89CA;

  sca_adc_ctrl #(.CLK_DIV(DIV), .HAS_STATUS(1'b1)) DUT (.core_clk(core_clk), .arst_n(arst_n),
    .csN(csN), .rdN(rdN), .wrN(wrN), .statusN(statusN), .modeSel(modeSel), .clkHalt(clkHalt),
    .dataIn(dataIn), .convResult(convResult), .dataOut(dataOut), .dataOe(dataOe), .intN(intN),
    .readyOut(readyOut), .sampleEn(sampleEn), .calOneCap(calOneCap), .calAllCaps(calAllCaps),
    .calCapIdx(calCapIdx), .calValid(calValid));
  // Variant without status logic on the same bus
  sca_adc_ctrl #(.CLK_DIV(DIV), .HAS_STATUS(1'b0)) DUT_FULL (.core_clk(core_clk),
    .arst_n(arst_n), .csN(csN), .rdN(rdN), .wrN(wrN), .statusN(statusN), .modeSel(modeSel),
    .clkHalt(clkHalt), .dataIn(dataIn), .convResult(convResult), .dataOut(altOut), .dataOe(),
    .intN(), .readyOut(), .sampleEn(), .calOneCap(), .calAllCaps(), .calCapIdx(), .calValid());
  sca_host_model host (.core_clk(core_clk), .dataOut(dataOut), .dataOe(dataOe),
    .altOut(altOut), .readyOut(readyOut), .csN(csN), .rdN(rdN), .wrN(wrN),
    .statusN(statusN), .dataIn(dataIn));

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Cycle count with hang limit
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // Xorshift source for results and ignored command bits
  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction : rnd
  // One comparison, reported at once on mismatch
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // Waits at falling edges for a level, bounded
  task automatic waitFor(ref logic sig, input logic lvl, input int lim);
    for (int i = 0; i < lim && sig !== lvl; i++) @(negedge core_clk);
    // A wait that runs out counts as a mismatch
    if (sig !== lvl) begin
      n_mismatch++;
      $display("BAD waitLevel expected %h seen %h", lvl, sig);
    end
  endtask : waitFor
  // Status read against the model; done clears afterwards
  task automatic readStatus(input logic act);
    logic [SCA_RES_W-1:0] v, oe, va;
    host.doRead(1'b1, v, oe, va);
    chk("statusByte", {24'h0, 1'b0, act, 3'b000, mPtr[0], mEoc[0], mDone[0]}, {24'h0, v[7:0]});
    chk("statusOe", 32'h00FF, {19'h0, oe});
    mDone = 0;
  endtask : readStatus
  // Result byte read; pointer selects upper or lower byte
  task automatic readData();
    logic [SCA_RES_W-1:0] v, oe, va, r;
    logic [31:0] e;
    r = mRes[12:0];
    e = (mPtr == 0) ? {24'h0, {4{r[12]}}, r[11:8]} : {24'h0, r[7:0]};
    host.doRead(1'b0, v, oe, va);
    chk("resultByte", e, {24'h0, v[7:0]});
    chk("fullWord", {19'h0, r}, {19'h0, va});
    chk("intCleared", 1, intN);
    mPtr = 1 - mPtr;
    mDone = 0;
  endtask : readData
  // Mode 1 start with a fresh result; returns capacitor in use
  task automatic startConv(output int t0, output logic [SCA_CAP_W-1:0] idx);
    t0 = cyc;
    mRes = int'(rnd() & 32'h1FFF);
    convResult = mRes[12:0];
    host.doWrite(1'b0, 6'h00);
    mEoc = 0;
    waitFor(calOneCap, 1'b1, 20);
    idx = calCapIdx;
  endtask : startConv
  // Completion timing from the start call
  task automatic finishConv(input int t0, input int lo);
    waitFor(intN, 1'b0, 400);
    chk("latency", 1, {31'h0, (cyc - t0 >= lo) && (cyc - t0 <= lo + 12)});
    mEoc = 1;
    mDone = 1;
  endtask : finishConv

  // Main sequence
  initial begin
    int t0;
    logic [31:0] r;
    logic [SCA_CAP_W-1:0] i0, i1, i2;
    arst_n = 1'b0;
    modeSel = 1'b0;
    clkHalt = 1'b0;
    convResult = 13'h0000;
    mPtr = 0;
    mEoc = 0;
    mDone = 0;
    mRes = 0;
    repeat (10) @(negedge core_clk);
    chk("oeReset", 0, {19'h0, dataOe});
    chk("intReset", 1, {31'h0, intN});
    arst_n = 1'b1;
    t0 = cyc;
    repeat (4) @(negedge core_clk);
    // Start during power-up calibration is ignored
    host.doWrite(1'b0, 6'h00);
    readStatus(1'b0);
    waitFor(calValid, 1'b1, 400);
    chk("powerUpCal", 1, {31'h0, (cyc - t0 >= 105 * DIV) && (cyc - t0 <= 105 * DIV + 8)});
    chk("intRefused", 1, {31'h0, intN});
    // Capacitor rotation with full readout each time
    for (int k = 0; k < 8; k++) begin
      startConv(t0, i1);
      if (k == 0) i0 = i1;
      chk("capIdx", (i0 + k) % 7, {29'h0, i1});
      finishConv(t0, 62 * DIV);
      readStatus(1'b0);
      readData();
      readData();
    end
    readData();
    // Abort before the window keeps the capacitor
    startConv(t0, i1);
    readStatus(1'b1);
    startConv(t0, i2);
    chk("capRepeat", {29'h0, i1}, {29'h0, i2});
    finishConv(t0, 62 * DIV);
    // Abort after the window moves on
    startConv(t0, i1);
    waitFor(sampleEn, 1'b1, 200);
    waitFor(sampleEn, 1'b0, 60);
    startConv(t0, i2);
    chk("capNext", (i1 + 1) % 7, {29'h0, i2});
    finishConv(t0, 62 * DIV);
    // Status write mid-conversion clears flags and aborts
    startConv(t0, i1);
    host.doWrite(1'b1, 6'h00);
    mPtr = 0;
    mEoc = 0;
    mDone = 0;
    readStatus(1'b0);
    repeat (150) @(negedge core_clk);
    chk("abortedInt", 1, {31'h0, intN});
    // Mode 2: calibration command then conversions
    modeSel = 1'b1;
    repeat (4) @(negedge core_clk);
    r = rnd();
    t0 = cyc;
    host.doWrite(1'b0, {1'b0, r[0], 4'h0});
    // Calibration must be seen running before its end is timed
    waitFor(calAllCaps, 1'b1, 20);
    waitFor(calAllCaps, 1'b0, 400);
    chk("calLength", 1, {31'h0, (cyc - t0 >= 105 * DIV + 4) && (cyc - t0 <= 105 * DIV + 14)});
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      t0 = cyc;
      mRes = int'(r & 32'h1FFF);
      convResult = r[12:0];
      host.doWrite(1'b0, {2'b10, r[15:13], 1'b0});
      mEoc = 0;
      finishConv(t0, 24 * DIV + 4);
      readStatus(1'b0);
      readData();
      readData();
    end
    // Stopped conversion clock drops calibration
    modeSel = 1'b0;
    clkHalt = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("calLost", 0, {31'h0, calValid});
    clkHalt = 1'b0;
    waitFor(calValid, 1'b1, 400);
    chk("calBack", 1, {31'h0, calValid});
    tally_and_finish();
  end
endmodule : sca_adc_ctrl_tb_top
